// ### hw/pwm_timer_pkg.sv
package pwm_timer_pkg;
    localparam int NUM_MATCH = 7;
    localparam int NUM_OUT   = 6;
    localparam int CNT_W     = 32;

    // register byte offsets
    localparam logic [7:0] OFS_IR    = 8'h00;
    localparam logic [7:0] OFS_TCR   = 8'h04;
    localparam logic [7:0] OFS_TC    = 8'h08;
    localparam logic [7:0] OFS_PR    = 8'h0C;
    localparam logic [7:0] OFS_PC    = 8'h10;
    localparam logic [7:0] OFS_MCR   = 8'h14;
    localparam logic [7:0] OFS_MR0   = 8'h18;
    localparam logic [7:0] OFS_CTCR  = 8'h34;
    localparam logic [7:0] OFS_PCR   = 8'h4C;
    localparam logic [7:0] OFS_LER   = 8'h50;
    localparam logic [7:0] OFS_IMASK = 8'h54;

    // control register fields
    localparam int TCR_EN_BIT    = 0;
    localparam int TCR_RST_BIT   = 1;
    localparam int TCR_PWMEN_BIT = 3;
    localparam int MCR_INT_BIT   = 0;
    localparam int MCR_RST_BIT   = 1;
    localparam int MCR_STOP_BIT  = 2;
    localparam int CTCR_SRC_BIT  = 2;
    localparam int PCR_SEL_LO    = 2;
    localparam int PCR_ENA_LO    = 9;

    localparam logic [31:0] RST_VAL = 32'h0000_0000;

    // counter modes
    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_RISE,
        MODE_FALL,
        MODE_BOTH
    } cnt_mode_t;
endpackage : pwm_timer_pkg

// ### hw/pwm_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_edge_detect
    import pwm_timer_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       sig,
    input  wire cnt_mode_t  mode,
    output logic            tick
);
    logic sig_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sig_r <= 1'b0;
        end else if (ce) begin
            sig_r <= sig;
        end
    end

    always_comb begin
        case (mode)
            MODE_RISE: tick = sig & ~sig_r;
            MODE_FALL: tick = ~sig & sig_r;
            MODE_BOTH: tick = sig ^ sig_r;
            default:   tick = 1'b0;
        endcase
    end
endmodule // pwm_edge_detect
`default_nettype wire

// ### hw/match_based_pwm_timer.sv
// Operation
// - A count equal to the period match register resets the count and starts a new cycle.
// - A single-edge output uses the period register plus one own match register for its edge.
// - Single-edge outputs go high at each period match unless held constant low.
// - A double-edge output uses the period register plus two match registers for its edges.
// - One match sets the rising edge, the other the falling edge, giving either pulse polarity.
// - Seven match registers serve up to six single-edge or three double-edge outputs or a mix.
// - Each match may continue, stop or reset the timer and may raise an interrupt.
// - In PWM mode, new match values take effect only after software releases them, at the cycle boundary.
// - With PWM mode off the block is a plain 32-bit timer/counter with a 32-bit prescaler.
// - The counter counts either the clock or edges on a selected capture input.
// - Period and width are any count, and all outputs share one period.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module match_based_pwm_timer
    import pwm_timer_pkg::*;
#(
    parameter int NCAP = 2
) (
    input  wire logic                 CLK,
    input  wire logic                 RESETN,
    input  wire logic                 CE,
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [7:0]           PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic      [31:0]          PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    input  wire logic [NCAP-1:0]      CAP_IN,
    output logic      [NUM_OUT-1:0]   PWM_OUT,
    output logic                      IRQ
);
    // only one or two capture inputs feed the edge selector
    if (NCAP < 1 || NCAP > 2) begin : g_ncap_check
        $error("NCAP must be 1 or 2");
    end

    // every output needs its own edge match next to the period match
    if (NUM_OUT >= NUM_MATCH || PCR_ENA_LO + NUM_OUT > 15
        || 3 * NUM_MATCH > 32) begin : g_size_check
        $error("output and match counts do not fit the register fields");
    end

    logic [NUM_MATCH-1:0]      ir_r;
    logic [NUM_MATCH-1:0]      imask_r;
    logic [3:0]                tcr_r;
    logic [CNT_W-1:0]          tc_r;
    logic [CNT_W-1:0]          pr_r;
    logic [CNT_W-1:0]          pc_r;
    logic [3*NUM_MATCH-1:0]    mcr_r;
    logic [3:0]                ctcr_r;
    logic [14:0]               pcr_r;
    logic [NUM_MATCH-1:0]      ler_r;
    logic [CNT_W-1:0]          shadow_r [NUM_MATCH];
    logic [CNT_W-1:0]          match_r  [NUM_MATCH];
    logic [NUM_OUT-1:0]        out_r;

    logic                      wr;
    logic                      rd_ok;
    logic [31:0]               rd_data;
    logic                      tick;
    logic                      pre_done;
    logic                      step;
    logic [NUM_MATCH-1:0]      hit;
    logic                      hit_rst;
    logic                      hit_stop;
    logic                      cap_sel;
    cnt_mode_t                 cnt_mode;
    logic                      cnt_ev;
    logic                      cnt_src;
    logic                      cycle_start;
    logic [NUM_MATCH-1:0]      mr_wr;
    logic [NUM_OUT-1:0]        out_set;
    logic [NUM_OUT-1:0]        out_clr;

    function automatic logic is_mr(input logic [7:0] a);
        return a >= OFS_MR0 && a < OFS_MR0 + 8'(4 * NUM_MATCH) && a[1:0] == 2'b00;
    endfunction

    function automatic int mr_idx(input logic [7:0] a);
        return int'((a - OFS_MR0) >> 2);
    endfunction

    // a completed write access to one register offset
    function automatic logic reg_wr(input logic [7:0] a);
        return wr && PADDR == a;
    endfunction

    assign PREADY  = 1'b1;
    assign wr      = PSEL & PENABLE & PWRITE & CE;
    assign PSLVERR = PSEL & PENABLE & ~rd_ok;

    // address decode and read mux
    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h0000_0000;
        if (is_mr(PADDR) && PADDR[1:0] == 2'b00) begin
            rd_data = shadow_r[mr_idx(PADDR)];
        end else begin
            case (PADDR)
                OFS_IR:    rd_data = 32'(ir_r);
                OFS_TCR:   rd_data = 32'(tcr_r);
                OFS_TC:    rd_data = tc_r;
                OFS_PR:    rd_data = pr_r;
                OFS_PC:    rd_data = pc_r;
                OFS_MCR:   rd_data = 32'(mcr_r);
                OFS_CTCR:  rd_data = 32'(ctcr_r);
                OFS_PCR:   rd_data = 32'(pcr_r);
                OFS_LER:   rd_data = 32'(ler_r);
                OFS_IMASK: rd_data = 32'(imask_r);
                default:   rd_ok   = 1'b0;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            PRDATA <= RST_VAL;
        end else if (CE && PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= rd_data;
        end
    end

    // counter source: clock or capture-input edges
    assign cnt_mode = cnt_mode_t'(ctcr_r[1:0]);
    assign cap_sel  = (NCAP > 1) ? CAP_IN[NCAP-1] & ctcr_r[CTCR_SRC_BIT] : 1'b0;
    assign cnt_src  = ctcr_r[CTCR_SRC_BIT] ? cap_sel : CAP_IN[0];

    pwm_edge_detect u_edge (
        .clk   (CLK),
        .rst_n (RESETN),
        .ce    (CE),
        .sig   (cnt_src),
        .mode  (cnt_mode),
        .tick  (tick)
    );

    // prescaler gates the timer increment
    assign pre_done = (pc_r == pr_r);
    assign cnt_ev   = tcr_r[TCR_EN_BIT] & ((cnt_mode == MODE_TIMER) | tick);
    assign step     = cnt_ev & ~tcr_r[TCR_RST_BIT] & pre_done;

    // match compare against the active values
    always_comb begin
        hit_rst  = 1'b0;
        hit_stop = 1'b0;
        for (int i = 0; i < NUM_MATCH; i++) begin
            hit[i] = step & (tc_r == match_r[i]);
            if (hit[i] && mcr_r[3*i+MCR_RST_BIT]) hit_rst = 1'b1;
            if (hit[i] && mcr_r[3*i+MCR_STOP_BIT]) hit_stop = 1'b1;
        end
        if (tcr_r[TCR_PWMEN_BIT] && hit[0]) hit_rst = 1'b1;
    end

    // a new pwm cycle starts on the period match or on a counter reset
    assign cycle_start = hit[0] | tcr_r[TCR_RST_BIT];

    // per-register match write strobes
    always_comb begin
        for (int i = 0; i < NUM_MATCH; i++) begin
            mr_wr[i] = wr && is_mr(PADDR) && mr_idx(PADDR) == i;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pc_r <= RST_VAL;
        end else if (CE) begin
            if (wr && PADDR == OFS_PC) begin
                pc_r <= PWDATA;
            end else if (tcr_r[TCR_RST_BIT]) begin
                pc_r <= RST_VAL;
            end else if (cnt_ev) begin
                pc_r <= pre_done ? RST_VAL : pc_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            tc_r <= RST_VAL;
        end else if (CE) begin
            if (wr && PADDR == OFS_TC) begin
                tc_r <= PWDATA;
            end else if (tcr_r[TCR_RST_BIT] || hit_rst) begin
                tc_r <= RST_VAL;
            end else if (step) begin
                tc_r <= tc_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            tcr_r <= 4'h0;
        end else if (CE) begin
            if (wr && PADDR == OFS_TCR) begin
                tcr_r <= PWDATA[3:0];
            end else if (hit_stop) begin
                tcr_r[TCR_EN_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pr_r <= RST_VAL;
        end else if (reg_wr(OFS_PR)) begin
            pr_r <= PWDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            mcr_r <= '0;
        end else if (reg_wr(OFS_MCR)) begin
            mcr_r <= PWDATA[3*NUM_MATCH-1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ctcr_r <= 4'h0;
        end else if (reg_wr(OFS_CTCR)) begin
            ctcr_r <= PWDATA[3:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pcr_r <= '0;
        end else if (reg_wr(OFS_PCR)) begin
            pcr_r <= PWDATA[14:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            imask_r <= '0;
        end else if (reg_wr(OFS_IMASK)) begin
            imask_r <= PWDATA[NUM_MATCH-1:0];
        end
    end

    // software writes land in the shadow copy
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            for (int i = 0; i < NUM_MATCH; i++) begin
                shadow_r[i] <= RST_VAL;
            end
        end else if (CE) begin
            for (int i = 0; i < NUM_MATCH; i++) begin
                if (mr_wr[i]) begin
                    shadow_r[i] <= PWDATA;
                end
            end
        end
    end

    // active copy: direct outside pwm mode, released values at a cycle start in it
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            for (int i = 0; i < NUM_MATCH; i++) begin
                match_r[i] <= RST_VAL;
            end
        end else if (CE) begin
            for (int i = 0; i < NUM_MATCH; i++) begin
                if (!tcr_r[TCR_PWMEN_BIT]) begin
                    match_r[i] <= mr_wr[i] ? PWDATA : shadow_r[i];
                end else if (ler_r[i] && cycle_start) begin
                    match_r[i] <= shadow_r[i];
                end
            end
        end
    end

    // release bits stay armed until the next cycle start
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ler_r <= '0;
        end else if (CE) begin
            if (reg_wr(OFS_LER)) begin
                ler_r <= ler_r | PWDATA[NUM_MATCH-1:0];
            end else if (cycle_start) begin
                ler_r <= '0;
            end
        end
    end

    // pwm outputs n = 1..6; select bit 2 belongs to output 2, double-edge uses match n-1 and n
    always_comb begin
        out_set = '0;
        out_clr = '0;
        for (int n = 1; n <= NUM_OUT; n++) begin
            if (n >= 2 && pcr_r[PCR_SEL_LO+n-2]) begin
                out_clr[n-1] = hit[n];
                out_set[n-1] = hit[n-1];
            end else begin
                out_clr[n-1] = hit[n];
                out_set[n-1] = hit[0] && match_r[n] != RST_VAL;
            end
        end
    end

    // clear wins when both edges fall on one count
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            out_r <= '0;
        end else if (CE && tcr_r[TCR_PWMEN_BIT]) begin
            for (int n = 0; n < NUM_OUT; n++) begin
                if (out_clr[n]) begin
                    out_r[n] <= 1'b0;
                end else if (out_set[n]) begin
                    out_r[n] <= 1'b1;
                end
            end
        end
    end

    // gated by per-output enables; six outputs from seven matches
    assign PWM_OUT = out_r & pcr_r[PCR_ENA_LO +: NUM_OUT];

    // sticky interrupt flags, write one to clear, set wins
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ir_r <= '0;
        end else if (CE) begin
            for (int i = 0; i < NUM_MATCH; i++) begin
                if (hit[i] && mcr_r[3*i+MCR_INT_BIT]) begin
                    ir_r[i] <= 1'b1;
                end else if (wr && PADDR == OFS_IR && PWDATA[i]) begin
                    ir_r[i] <= 1'b0;
                end
            end
        end
    end

    assign IRQ = |(ir_r & imask_r);
endmodule // match_based_pwm_timer
`default_nettype wire

// ### dv/pwm_load_model.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_load_model (
    input  wire logic        clk,
    input  wire logic [5:0]  pwm,
    input  wire logic [2:0]  sel,
    output logic      [31:0] per_r,
    output logic      [31:0] hi_r
);
    logic        prev_r = 1'b0;
    logic [31:0] cnt_r  = 32'h0;
    logic [31:0] hcnt_r = 32'h0;
    // a rising edge ends the current cycle; latch its length and high time
    always @(posedge clk) begin
        prev_r <= pwm[sel];
        if (pwm[sel] && !prev_r) begin
            per_r  <= cnt_r;
            hi_r   <= hcnt_r;
            cnt_r  <= 32'h1;
            hcnt_r <= 32'h1;
        end else begin
            cnt_r  <= cnt_r + 32'h1;
            hcnt_r <= hcnt_r + {31'h0, pwm[sel]};
        end
    end
endmodule // pwm_load_model
`default_nettype wire

// ### dv/match_based_pwm_timer_properties.sv
`timescale 1ns/10ps
`default_nettype none
module match_based_pwm_timer_properties
    import pwm_timer_pkg::*;
#(
    parameter int NCAP = 2
) (
    input wire logic               CLK,
    input wire logic               RESETN,
    input wire logic               CE,
    input wire logic               PSEL,
    input wire logic               PENABLE,
    input wire logic               PWRITE,
    input wire logic [7:0]         PADDR,
    input wire logic [31:0]        PWDATA,
    input wire logic [31:0]        PRDATA,
    input wire logic               PREADY,
    input wire logic               PSLVERR,
    input wire logic [NCAP-1:0]    CAP_IN,
    input wire logic [NUM_OUT-1:0] PWM_OUT,
    input wire logic               IRQ
);
    logic        wr;
    logic        mapped;
    logic [31:0] pcr_r;
    logic [31:0] pcr_old_r;
    logic [6:0]  mask_r;
    logic [6:0]  mask_old_r;
    assign wr = PSEL && PENABLE && PWRITE && CE;
    assign mapped = PADDR[1:0] == 2'h0 && (PADDR <= OFS_CTCR || PADDR >= OFS_PCR && PADDR <= OFS_IMASK);
    // shadows of the config registers; like every write they need CE high
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            {pcr_r, pcr_old_r, mask_r, mask_old_r} <= '0;
        end else begin
            pcr_old_r <= pcr_r;
            mask_old_r <= mask_r;
            if (wr && PADDR == OFS_PCR) pcr_r <= PWDATA;
            if (wr && PADDR == OFS_IMASK) mask_r <= PWDATA[6:0];
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    a_ready_high: assert property (PREADY) else $error("pready low");
    a_err_decode: assert property (PSEL && PENABLE |-> PSLVERR == !mapped) else $error("pslverr decode");
    a_err_idle: assert property (!PSEL |-> !PSLVERR) else $error("pslverr while idle");
    a_rdata_unmapped: assert property (PSEL && PENABLE && !PWRITE && !mapped |-> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_out_frozen: assert property (!CE && !wr |=> $stable(PWM_OUT)) else $error("outputs moved with ce low");
    a_irq_frozen: assert property (!CE && !wr |=> $stable(IRQ)) else $error("irq moved with ce low");
    a_out_gated: assert property ((PWM_OUT & ~(pcr_r[14:9] | pcr_old_r[14:9])) == 6'h0)
        else $error("disabled output high");
    a_irq_masked: assert property (mask_r == 7'h0 && mask_old_r == 7'h0 |-> !IRQ)
        else $error("irq with all masked");
endmodule // match_based_pwm_timer_properties
bind match_based_pwm_timer match_based_pwm_timer_properties #(.NCAP(NCAP)) i_match_based_pwm_timer_properties (
    .CLK(CLK), .RESETN(RESETN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CAP_IN(CAP_IN), .PWM_OUT(PWM_OUT), .IRQ(IRQ));
`default_nettype wire

// ### dv/match_based_pwm_timer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module match_based_pwm_timer_tb_top
    import pwm_timer_pkg::*;
;
    logic        clk = 1'b0, resetn = 1'b0, ce = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, v, per, hi;
    logic [1:0]  cap_in = 2'h0;
    logic [5:0]  pwm_out;
    logic [2:0]  sel = 3'h0;
    int          bad_count = 0, tests_run = 0;
    always #20 clk = ~clk;
    match_based_pwm_timer #(.NCAP(2)) i_match_based_pwm_timer (.CLK(clk), .RESETN(resetn), .CE(ce),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CAP_IN(cap_in), .PWM_OUT(pwm_out),
        .IRQ(irq));
    pwm_load_model i_pwm_load_model (.clk(clk), .pwm(pwm_out), .sel(sel), .per_r(per), .hi_r(hi));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_timer();
        apb(1, 8'h30, 32'h0000_00A5);
        apb(0, 8'h30, 0);
        check("mr6", 32'h0000_00A5, rd);
        apb(0, 8'h40, 0);
        check("unmapped", 32'h0, rd);
        check("unmapped_err", 32'h1, err);
        apb(1, OFS_PR, 32'h1);
        apb(1, OFS_MR0, 32'h0000_0100);
        apb(1, OFS_TCR, 32'h2);
        apb(1, OFS_TCR, 32'h1);
        apb(0, OFS_TC, 0);
        v = rd;
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        repeat (17) @(posedge clk);
        apb(0, OFS_TC, 0);
        check("tc_step", v + 32'hA, rd);
    endtask
    task automatic t_irq();
        apb(1, OFS_PR, 32'h0);
        apb(1, OFS_MR0, 32'h20);
        apb(1, OFS_MCR, 32'h5);
        apb(1, OFS_TCR, 32'h2);
        apb(1, OFS_TCR, 32'h1);
        repeat (50) @(posedge clk);
        check("irq_masked", 0, irq);
        apb(0, OFS_IR, 0);
        check("ir_flag", 1, rd[0]);
        apb(0, OFS_TC, 0);
        v = rd;
        repeat (10) @(posedge clk);
        apb(0, OFS_TC, 0);
        check("tc_stopped", v, rd);
        apb(1, OFS_IMASK, 32'h1);
        @(posedge clk);
        check("irq_up", 1, irq);
        apb(1, OFS_MR0, 32'h0000_1000);
        apb(1, OFS_IR, 32'h1);
        @(posedge clk);
        check("irq_clear", 0, irq);
        apb(1, OFS_MCR, 32'h0);
    endtask
    task automatic pulses(input logic [1:0] p);
        repeat (3) begin
            cap_in <= p;
            repeat (3) @(posedge clk);
            cap_in <= 2'h0;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic t_counter();
        apb(1, OFS_CTCR, 32'h1);
        apb(1, OFS_TCR, 32'h2);
        apb(1, OFS_TCR, 32'h1);
        pulses(2'h1);
        apb(0, OFS_TC, 0);
        check("edge_count", 32'h3, rd);
        apb(1, OFS_CTCR, 32'h7);
        apb(1, OFS_TCR, 32'h2);
        apb(1, OFS_TCR, 32'h1);
        pulses(2'h2);
        apb(0, OFS_TC, 0);
        check("both_count", 32'h6, rd);
        apb(1, OFS_CTCR, 32'h2);
        apb(1, OFS_TCR, 32'h2);
        apb(1, OFS_TCR, 32'h1);
        pulses(2'h1);
        apb(0, OFS_TC, 0);
        check("fall_count", 32'h3, rd);
        apb(1, OFS_CTCR, 32'h0);
    endtask
    task automatic t_pwm();
        apb(1, OFS_TCR, 32'h2);
        apb(1, OFS_MR0, 32'h9);
        apb(1, OFS_MR0 + 8'h4, 32'h4);
        apb(1, OFS_LER, 32'h3);
        apb(1, OFS_PCR, 32'h0000_3E00);
        apb(1, OFS_TCR, 32'hB);
        apb(1, OFS_TCR, 32'h9);
        repeat (40) @(posedge clk);
        check("period", 32'hA, per);
        check("const_low", 0, pwm_out[2]);
        v = hi;
        apb(1, OFS_MR0 + 8'h4, 32'h7);
        repeat (30) @(posedge clk);
        check("held", v, hi);
        apb(1, OFS_LER, 32'h2);
        repeat (30) @(posedge clk);
        check("width", v + 32'h3, hi);
        apb(1, OFS_PCR, 32'h0000_3E04);
        apb(1, OFS_MR0 + 8'h4, 32'h2);
        apb(1, OFS_MR0 + 8'h8, 32'h6);
        apb(1, OFS_LER, 32'h6);
        sel <= 3'h1;
        repeat (40) @(posedge clk);
        check("pos_pulse", 32'h4, hi);
        apb(1, OFS_MR0 + 8'h4, 32'h6);
        apb(1, OFS_MR0 + 8'h8, 32'h2);
        apb(1, OFS_LER, 32'h6);
        repeat (40) @(posedge clk);
        check("neg_pulse", 32'h6, hi);
        check("period2", 32'hA, per);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_timer();
        t_irq();
        t_counter();
        t_pwm();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        stop_test();
    end
endmodule // match_based_pwm_timer_tb_top
`default_nettype wire
